// ---- verilog/xpsw_pkg.sv ----
// Purpose: Shared constants and types for the crosspoint switch programming link.
// Assumes: One device of 16 outputs by 16 inputs per link; 32-bit AXI4-Lite data.
// Notes: Each slot is packed as {source_select, output_on}, output_on in bit 0.
package xpsw_pkg;
    // ****************************************************************
    // Matrix geometry
    // ****************************************************************
    localparam int NUM_OUT = 16;
    localparam int NUM_IN = 16;
    localparam int SRC_W = 4;
    localparam int IDX_W = 4;
    localparam int SLOT_W = 5;
    localparam int SR_LEN = 80;
    localparam int SLOT_ON_BIT = 0;
    localparam int SLOT_SRC_LSB = 1;

    // ****************************************************************
    // Controller register map (byte addresses) and fields
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_PAR = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_IMG0 = 8'h10;
    localparam logic [ADDR_W-1:0] REG_IMG1 = 8'h14;
    localparam logic [ADDR_W-1:0] REG_IMG2 = 8'h18;
    localparam int IMG2_W = SR_LEN - 64;
    localparam int CTRL_RESET_BIT = 0;
    localparam int CMD_SERIAL_BIT = 0;
    localparam int CMD_PAR_BIT = 1;
    localparam int CMD_APPLY_BIT = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SOUT_BIT = 1;
    localparam int PAR_ON_BIT = 0;
    localparam int PAR_SRC_LSB = 1;
    localparam int PAR_IDX_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;

    // ****************************************************************
    // Pin timing: clk cycles each pin level is held by the controller
    // ****************************************************************
    localparam logic [2:0] PHASE_CYCLES = 3'h4;

    typedef logic [SLOT_W-1:0] xpsw_slot_t;
    typedef enum {
        XPSW_IDLE, XPSW_SER_HI, XPSW_SER_LO, XPSW_PAR_HI, XPSW_PAR_LO, XPSW_APPLY, XPSW_DONE
    } xpsw_seq_t;
endpackage

// ---- verilog/xpsw_if.sv ----
// Purpose: Load-port pins between the programming controller and the switch device.
// Assumes: Both ends run on the same system clock; the device resynchronises every pin except the assertion of outputs_reset_n.
// Notes: All pins are one-way; there is no two-way pin on this link.
`timescale 1ns/1ps
interface xpsw_if;
    import xpsw_pkg::*;
    logic load_clk;
    logic chip_select_n;
    logic latch_update_n;
    logic serial_parallel_select;
    logic serial_in;
    logic serial_out;
    logic outputs_reset_n;
    logic [IDX_W-1:0] output_index;
    logic [SRC_W-1:0] source_select;
    logic output_on;

    modport ctrl (
        output load_clk, chip_select_n, latch_update_n, serial_parallel_select, serial_in,
        output outputs_reset_n, output_index, source_select, output_on,
        input serial_out
    );
    modport dev (
        input load_clk, chip_select_n, latch_update_n, serial_parallel_select, serial_in,
        input outputs_reset_n, output_index, source_select, output_on,
        output serial_out
    );
endinterface

// ---- verilog/xpsw_slot_decode.sv ----
// Purpose: Turn one latched slot into a one-hot input enable vector.
// Assumes: Slot packed as {source_select, output_on}.
// Notes: Purely combinational.
`timescale 1ns/1ps
module xpsw_slot_decode
    import xpsw_pkg::*;
(
    // Slot in
    input wire xpsw_pkg::xpsw_slot_t slot,
    // Enables out
    output logic [xpsw_pkg::NUM_IN-1:0] select
);
    import xpsw_pkg::*;

    // A disabled output routes nothing, whatever its source field holds.
    always_comb begin
        if (slot[SLOT_ON_BIT]) begin
            select = {{(NUM_IN-1){1'b0}}, 1'b1} << slot[SLOT_W-1:SLOT_SRC_LSB];
        end else begin
            select = '0;
        end
    end
endmodule

// ---- verilog/xpsw_device.sv ----
// Purpose: Load logic of a 16 by 16 crosspoint switch: shift register, update latch,
//          per-output decoding and the output disable.
// Assumes: Every link pin is asynchronous to clk; all but outputs_reset_n pass two flip-flops first.
// Notes: Falling load_clk edges are found in the clk domain after synchronisation.
`timescale 1ns/1ps
module xpsw_device
    import xpsw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Load port
    xpsw_if.dev link,
    // Matrix control
    output logic [xpsw_pkg::NUM_OUT-1:0][xpsw_pkg::NUM_IN-1:0] route_select,
    output logic [xpsw_pkg::NUM_OUT-1:0] output_enabled,
    // Observation of the two ranks
    output logic [xpsw_pkg::SR_LEN-1:0] shift_state,
    output logic [xpsw_pkg::SR_LEN-1:0] latch_state
);
    import xpsw_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int PIN_W = 5 + IDX_W + SRC_W + 1;
    // Idle levels: load clock high, select and update deasserted.
    localparam logic [PIN_W-1:0] PIN_IDLE = {1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
                                             {IDX_W{1'b0}}, {SRC_W{1'b0}}, 1'b0};

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic rst_meta;
    logic rst_sync;

    // All pins but outputs_reset_n pass the same two stages, so data and load clock stay aligned.
    assign pin_raw = {link.load_clk, link.chip_select_n, link.latch_update_n,
                      link.serial_parallel_select, link.serial_in,
                      link.output_index, link.source_select, link.output_on};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    logic sclk;
    logic scs_n;
    logic supd_n;
    logic ssps;
    logic ssin;
    logic [IDX_W-1:0] sidx;
    logic [SRC_W-1:0] ssrc;
    logic son;

    assign {sclk, scs_n, supd_n, ssps, ssin, sidx, ssrc, son} = pin_sync;

    // ****************************************************************
    // Load clock edge detection and mode decode
    // ****************************************************************
    logic clk_prev;
    logic clk_fall;
    logic do_shift;
    logic do_slot;
    logic do_latch;

    // Starting at the idle high level keeps reset release from faking a fall.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clk_prev <= 1'b1;
        end else begin
            clk_prev <= sclk;
        end
    end

    // Shift and slot write share the synchronised fall; the mode pin picks one.
    assign clk_fall = clk_prev & ~sclk;
    assign do_shift = clk_fall & ~scs_n & ~ssps;
    assign do_slot = clk_fall & ~scs_n & ssps;
    assign do_latch = ~scs_n & ~supd_n;

    // ****************************************************************
    // First rank: 80-bit shift register
    // ****************************************************************
    // Serial data enters at bit 0 and moves upward, so after a full load the
    // first bit sent (slot 15 source MSB) stands in bit 79 and each slot k sits
    // in bits 5k+4 down to 5k as {source_select, output_on}.
    logic [SR_LEN-1:0] shift_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_reg <= '0;
        end else if (do_shift) begin
            shift_reg <= {shift_reg[SR_LEN-2:0], ssin};
        end else if (do_slot) begin
            // Only the addressed five bits move; every other slot keeps its value.
            shift_reg[SLOT_W*sidx +: SLOT_W] <= {ssrc, son};
        end
    end

    // The last stage drives the chain; a bit stands here 79 edges after entry.
    assign link.serial_out = shift_reg[SR_LEN-1];
    assign shift_state = shift_reg;

    // ****************************************************************
    // Second rank: update latch
    // ****************************************************************
    // While transparent the latch follows every intermediate shift value, so
    // the controller keeps update high during loading.
    // A deselected device keeps its latch whatever the update pin does.
    logic [SR_LEN-1:0] latch_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_reg <= '0;
        end else if (do_latch) begin
            latch_reg <= shift_reg;
        end
    end

    assign latch_state = latch_reg;

    // ****************************************************************
    // Output disable
    // ****************************************************************
    // The reset pin clears the route flops at once and its synchronised copy
    // holds them clear until release; both ranks keep their contents.
    // Release is synchronised so every output comes back on the same clk edge.
    logic route_rst_n;

    assign route_rst_n = nrst & link.outputs_reset_n;

    always_ff @(posedge clk or negedge route_rst_n) begin
        if (!route_rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ****************************************************************
    // Per-output decoding
    // ****************************************************************
    // Each output decodes its own latched slot, one clk after the latch.
    genvar k;
    generate
        for (k = 0; k < NUM_OUT; k++) begin : g_out
            logic [NUM_IN-1:0] dec_sel;

            xpsw_slot_decode u_dec (
                .slot(latch_reg[SLOT_W*k +: SLOT_W]),
                .select(dec_sel)
            );

            always_ff @(posedge clk or negedge route_rst_n) begin
                if (!route_rst_n) begin
                    route_select[k] <= '0;
                end else if (!rst_sync) begin
                    route_select[k] <= '0;
                end else begin
                    route_select[k] <= dec_sel;
                end
            end

            always_ff @(posedge clk or negedge route_rst_n) begin
                if (!route_rst_n) begin
                    output_enabled[k] <= 1'b0;
                end else if (!rst_sync) begin
                    output_enabled[k] <= 1'b0;
                end else begin
                    output_enabled[k] <= latch_reg[SLOT_W*k + SLOT_ON_BIT];
                end
            end
        end
    endgenerate
endmodule

// ---- verilog/xpsw_ctrl.sv ----
// Purpose: Programming controller that drives the switch load port from AXI4-Lite.
// Assumes: One device on the link; software loads the image before any apply.
// Notes: Commands written while busy are dropped; status bit 0 shows busy.
`timescale 1ns/1ps
module xpsw_ctrl
    import xpsw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite write channels
    input wire logic [xpsw_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [xpsw_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Load port
    xpsw_if.ctrl link
);
    import xpsw_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic ctrl_reset;
    logic [31:0] par_reg;
    logic [SR_LEN-1:0] img;
    logic busy;
    logic sout_meta;
    logic sout_sync;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign s_axi_bresp = RESP_OKAY;
    assign s_axi_rresp = RESP_OKAY;
    assign wr_go = aw_held & w_held;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reset <= 1'b0;
            par_reg <= '0;
            img <= '0;
        end else if (wr_go) begin
            case (aw_addr)
                REG_CTRL: ctrl_reset <= w_strb[0] & w_data[CTRL_RESET_BIT];
                REG_PAR: par_reg <= merge(par_reg, w_data, w_strb);
                REG_IMG0: img[31:0] <= merge(img[31:0], w_data, w_strb);
                REG_IMG1: img[63:32] <= merge(img[63:32], w_data, w_strb);
                REG_IMG2: img[SR_LEN-1:64] <= IMG2_W'(merge({16'h0000, img[SR_LEN-1:64]},
                                                            w_data, w_strb));
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= 32'(ctrl_reset) << CTRL_RESET_BIT;
                REG_STATUS: s_axi_rdata <= (32'(busy) << STAT_BUSY_BIT)
                                         | (32'(sout_sync) << STAT_SOUT_BIT);
                REG_PAR: s_axi_rdata <= par_reg;
                REG_IMG0: s_axi_rdata <= img[31:0];
                REG_IMG1: s_axi_rdata <= img[63:32];
                REG_IMG2: s_axi_rdata <= {16'h0000, img[SR_LEN-1:64]};
                default: s_axi_rdata <= '0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sout_meta <= 1'b0;
            sout_sync <= 1'b0;
        end else begin
            sout_meta <= link.serial_out;
            sout_sync <= sout_meta;
        end
    end

    // ****************************************************************
    // Load sequencer
    // ****************************************************************
    xpsw_seq_t state;
    logic [2:0] timer;
    logic [6:0] bit_cnt;
    logic cmd_wr;

    assign busy = (state != XPSW_IDLE);
    assign cmd_wr = wr_go && (aw_addr == REG_CMD) && w_strb[0];
    assign link.outputs_reset_n = ~ctrl_reset;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= XPSW_IDLE;
            timer <= '0;
            bit_cnt <= '0;
            link.load_clk <= 1'b1;
            link.chip_select_n <= 1'b1;
            link.latch_update_n <= 1'b1;
            link.serial_parallel_select <= 1'b0;
            link.serial_in <= 1'b0;
            link.output_index <= '0;
            link.source_select <= '0;
            link.output_on <= 1'b0;
        end else begin
            case (state)
                XPSW_IDLE: begin
                    timer <= PHASE_CYCLES - 3'h1;
                    if (cmd_wr && w_data[CMD_SERIAL_BIT]) begin
                        link.chip_select_n <= 1'b0;
                        link.serial_parallel_select <= 1'b0;
                        link.serial_in <= img[SR_LEN-1];
                        bit_cnt <= 7'(SR_LEN - 1);
                        state <= XPSW_SER_HI;
                    end else if (cmd_wr && w_data[CMD_PAR_BIT]) begin
                        link.chip_select_n <= 1'b0;
                        link.serial_parallel_select <= 1'b1;
                        link.output_index <= par_reg[PAR_IDX_LSB +: IDX_W];
                        link.source_select <= par_reg[PAR_SRC_LSB +: SRC_W];
                        link.output_on <= par_reg[PAR_ON_BIT];
                        state <= XPSW_PAR_HI;
                    end else if (cmd_wr && w_data[CMD_APPLY_BIT]) begin
                        link.chip_select_n <= 1'b0;
                        link.latch_update_n <= 1'b0;
                        state <= XPSW_APPLY;
                    end
                end
                XPSW_SER_HI, XPSW_PAR_HI: begin
                    timer <= timer - 3'h1;
                    if (timer == '0) begin
                        link.load_clk <= 1'b0;
                        timer <= PHASE_CYCLES - 3'h1;
                        state <= (state == XPSW_SER_HI) ? XPSW_SER_LO : XPSW_PAR_LO;
                    end
                end
                XPSW_SER_LO: begin
                    timer <= timer - 3'h1;
                    if (timer == '0) begin
                        link.load_clk <= 1'b1;
                        timer <= PHASE_CYCLES - 3'h1;
                        if (bit_cnt == '0) begin
                            state <= XPSW_DONE;
                        end else begin
                            bit_cnt <= bit_cnt - 7'h01;
                            link.serial_in <= img[bit_cnt - 7'h01];
                            state <= XPSW_SER_HI;
                        end
                    end
                end
                XPSW_PAR_LO, XPSW_APPLY: begin
                    timer <= timer - 3'h1;
                    if (timer == '0) begin
                        link.load_clk <= 1'b1;
                        link.latch_update_n <= 1'b1;
                        timer <= PHASE_CYCLES - 3'h1;
                        state <= XPSW_DONE;
                    end
                end
                XPSW_DONE: begin
                    timer <= timer - 3'h1;
                    if (timer == '0) begin
                        link.chip_select_n <= 1'b1;
                        link.serial_parallel_select <= 1'b0;
                        state <= XPSW_IDLE;
                    end
                end
                default: state <= XPSW_IDLE;
            endcase
        end
    end
endmodule

// ---- testbench/xpsw_link_checker.sv ----
// Purpose: Assertions on the load-port pins between controller and device.
// Assumes: The controller holds each pin level for four clk cycles.
// Notes: Instantiated in tb beside the link interface.
`timescale 1ns/1ps
module xpsw_link_checker
    import xpsw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Link pins
    input wire logic load_clk,
    input wire logic chip_select_n,
    input wire logic latch_update_n,
    input wire logic serial_parallel_select,
    input wire logic serial_in,
    input wire logic [xpsw_pkg::IDX_W-1:0] output_index,
    input wire logic [xpsw_pkg::SRC_W-1:0] source_select,
    input wire logic output_on
);
    import xpsw_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic prev_clk;
    logic [7:0] falls;
    // Counts serial falling edges inside one select window.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_clk <= 1'b1;
            falls <= 8'h00;
        end else begin
            prev_clk <= load_clk;
            if (chip_select_n) begin
                falls <= 8'h00;
            end else if (prev_clk && !load_clk && !serial_parallel_select) begin
                falls <= falls + 8'h01;
            end
        end
    end
    a_clk_when_selected: assert property ($fell(load_clk) |-> !chip_select_n)
        else $error("load clock fell while deselected");
    a_release_idle: assert property ($rose(chip_select_n) |-> load_clk && latch_update_n)
        else $error("deselect with pins not idle");
    a_shift_upd_high: assert property ($fell(load_clk) && !serial_parallel_select |->
        latch_update_n)
        else $error("serial shift with update low");
    a_par_setup_ok: assert property ($fell(load_clk) && serial_parallel_select |->
        latch_update_n)
        else $error("parallel write with update low");
    a_clk_low_time: assert property ($fell(load_clk) |-> !load_clk [*4] ##1 load_clk)
        else $error("load clock low phase wrong");
    a_data_steady: assert property (!load_clk |->
        $stable({serial_in, output_index, source_select, output_on}))
        else $error("data moved while load clock low");
    a_mode_steady: assert property (!chip_select_n && !$past(chip_select_n) |->
        $stable(serial_parallel_select))
        else $error("mode changed while selected");
    a_serial_count: assert property ($rose(chip_select_n) && falls != 8'h00 |->
        falls == 8'(SR_LEN))
        else $error("serial load not 80 bits");
    a_update_pulse: assert property ($fell(latch_update_n) |->
        (!chip_select_n && !latch_update_n) [*4] ##1 latch_update_n)
        else $error("update pulse malformed");
endmodule

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for controller and device joined by the link.
// Assumes: AXI4-Lite writes and reads drive every command.
// Notes: Expected images are built here from the slot layout.
`timescale 1ns/1ps
module tb;
    import xpsw_pkg::*;
    logic clk, nrst, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [1:0] bresp, rresp;
    logic [NUM_OUT-1:0][NUM_IN-1:0] route;
    logic [NUM_OUT-1:0] oen;
    logic [SR_LEN-1:0] shift_q, latch_q, img, old;
    int err_count, checks_done;
    xpsw_if link();
    xpsw_ctrl u_xpsw_ctrl(.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .link(link));
    xpsw_device u_xpsw_device(.clk(clk), .nrst(nrst), .link(link), .route_select(route),
        .output_enabled(oen), .shift_state(shift_q), .latch_state(latch_q));
    xpsw_link_checker u_xpsw_link_checker(.clk(clk), .nrst(nrst), .load_clk(link.load_clk),
        .chip_select_n(link.chip_select_n), .latch_update_n(link.latch_update_n),
        .serial_parallel_select(link.serial_parallel_select), .serial_in(link.serial_in),
        .output_index(link.output_index), .source_select(link.source_select),
        .output_on(link.output_on));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [SR_LEN-1:0] got, input logic [SR_LEN-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic hang();
        err_count++;
        $display("MISMATCH t=%0t wait timed out", $time);
        tally_and_finish();
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        if (!bvalid) hang();
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        d = rdata;
        if (!rvalid) hang();
    endtask
    // Issues one command and polls the busy flag until it clears.
    task automatic run_cmd(input logic [31:0] c);
        logic [31:0] s;
        int n;
        wr(REG_CMD, c);
        n = 0;
        do begin
            rd(REG_STATUS, s);
            n++;
        end while (s[STAT_BUSY_BIT] !== 1'b0 && n < 1000);
        if (s[STAT_BUSY_BIT] !== 1'b0) hang();
    endtask
    task automatic check_matrix(input logic [SR_LEN-1:0] im);
        for (int k = 0; k < NUM_OUT; k++) begin
            chk(SR_LEN'(oen[k]), SR_LEN'(im[5*k]));
            chk(SR_LEN'(route[k]),
                SR_LEN'(im[5*k] ? 16'h0001 << im[5*k+1 +: 4] : 16'h0000));
        end
    endtask
    initial begin
        nrst = 1'b0;
        {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
        err_count = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < NUM_OUT; k++) begin
            img[5*k +: 5] = {4'(k), 1'(k % 3 != 0)};
        end
        wr(REG_IMG0, img[31:0]);
        wr(REG_IMG1, img[63:32]);
        wr(REG_IMG2, {16'h0000, img[79:64]});
        run_cmd(32'h0000_0001);
        chk(shift_q, img);
        chk(latch_q, {SR_LEN{1'b0}});
        chk(SR_LEN'(link.serial_out), SR_LEN'(img[79]));
        rd(REG_STATUS, rv);
        chk(SR_LEN'(rv[STAT_SOUT_BIT]), SR_LEN'(img[79]));
        run_cmd(32'h0000_0004);
        check_matrix(img);
        $display("test serial load done");
        old = img;
        img[4:0] = 5'h0B;
        img[79:75] = 5'h13;
        wr(REG_PAR, 32'h0000_000B);
        run_cmd(32'h0000_0002);
        wr(REG_PAR, 32'h0000_0F13);
        run_cmd(32'h0000_0002);
        chk(shift_q, img);
        chk(latch_q, old);
        check_matrix(old);
        run_cmd(32'h0000_0004);
        check_matrix(img);
        $display("test parallel write done");
        wr(REG_CTRL, 32'h0000_0001);
        @(posedge clk);
        check_matrix({SR_LEN{1'b0}});
        chk(latch_q, img);
        chk(shift_q, img);
        wr(REG_CTRL, 32'h0000_0000);
        repeat (4) @(posedge clk);
        check_matrix(img);
        $display("test output reset done");
        tally_and_finish();
    end
endmodule
